// file: common/dp_pkg.sv
// Purpose: Constants and types for the 8-bit programmable datapath slice.
// Assumes: One clock, synchronous active-high reset, plain register port.
// Notes: Summary of operation follows.
// Summary of operation
// - Two masked comparators; operands drawn from both accumulators and data registers.
// - Zero, all-ones and overflow detect join compare results as primary outputs.
// - Zero and equal conditions chain from the neighbour slice without general routing.
// - Programmable MSB sets arithmetic, shift and carry width with output masking.
// - One CRC or pseudo-random step per clock, polynomial and width programmable.
// - Longer CRC uses the chained shift input from a neighbour; pseudo-random steps ignore it.
// - Two four-byte FIFOs, each set as bus-to-datapath or datapath-to-bus.
// - FIFO empty and full flags are selectable slice outputs.
// - Carry, shift data and conditions optionally exchanged with adjacent slices.
// - Time multiplexing: one ALU, two register sets, registered carry feeds next cycle.
// - Exactly six routing inputs and six routing outputs.
// - Each routing output selects a condition or the serial data output.
// - Bus-written control register drives its bits into the routing.
// - Read-only status register shows routing signals on the bus.
// - Every status bit selects its own source; control bits each route out.
// - A sticky status bit holds a pulse until read; the read clears it.
// - A control bit can serve as clock enable for tile processing.
// - Shift left, shift right, nibble swap and OR mask act on the result.
package dp_pkg;
   localparam int W = 8;
   localparam int FDEPTH = 4;
   localparam int NROUTE = 6;
   localparam int NCOND = 16;
   // Register addresses
   localparam logic [4:0] A_ACC0 = 5'h00;
   localparam logic [4:0] A_ACC1 = 5'h01;
   localparam logic [4:0] A_DAT0 = 5'h02;
   localparam logic [4:0] A_DAT1 = 5'h03;
   localparam logic [4:0] A_FIFO0 = 5'h04;
   localparam logic [4:0] A_FIFO1 = 5'h05;
   localparam logic [4:0] A_CFG = 5'h06;
   localparam logic [4:0] A_POLY = 5'h07;
   localparam logic [4:0] A_CMASK = 5'h08;
   localparam logic [4:0] A_ORMASK = 5'h09;
   localparam logic [4:0] A_OSEL = 5'h0a;
   localparam logic [4:0] A_CTRL = 5'h0d;
   localparam logic [4:0] A_STAT = 5'h0e;
   localparam logic [4:0] A_SMODE = 5'h0f;
   localparam logic [4:0] A_STSEL = 5'h10;
   localparam logic [4:0] A_CFG2 = 5'h11;
   // Field positions
   localparam int C_F0OUT = 3;
   localparam int C_TMUX = 5;
   localparam int C_CHAIN = 6;
   localparam int C_PRS = 7;
   localparam int X_CSEL = 2;
   localparam int X_RGATE = 6;
   localparam int R_SET = 3;
   localparam int R_SIN = 4;
   localparam int R_FSTB = 5;
   // Values after reset
   localparam logic [7:0] RST_WORD = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h07;
   localparam logic [7:0] RST_CMASK = 8'hff;
   localparam logic [3:0] RST_OSEL = 4'h0;
   typedef enum logic [2:0] {OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_XOR, OP_AND, OP_CRC} op_t;
   typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} sh_t;
endpackage

// file: common/fifo_if.sv
// Purpose: Push/pop port between the slice and one of its byte FIFOs.
// Assumes: Single clock domain.
// Notes: Storage side drives data out and flags.
`timescale 1ns/1ns
interface fifo_if;
   logic push;
   logic pop;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic empty;
   logic full;
   modport store (input push, pop, wdata, output rdata, empty, full);
   modport user (output push, pop, wdata, input rdata, empty, full);
endinterface

// file: hw/byte_fifo.sv
// Purpose: Four-byte FIFO with empty and full flags.
// Assumes: Push on full and pop on empty are dropped.
// Notes: Head byte is visible on rdata while not empty.
`timescale 1ns/1ns
module byte_fifo (
   input wire logic clk, // Clock
   input wire logic srst, // Sync reset
   fifo_if.store p // Push/pop port
);
   logic [7:0] mem_r [dp_pkg::FDEPTH];
   logic [7:0] mem_nxt [dp_pkg::FDEPTH];
   logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic do_push, do_pop;

   always_comb begin
      do_push = p.push && (cnt_r != 3'(dp_pkg::FDEPTH));
      do_pop = p.pop && (cnt_r != 3'h0);
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (do_push) begin
         mem_nxt[wp_r] = p.wdata;
         wp_nxt = wp_r + 2'h1;
      end
      if (do_pop) begin
         rp_nxt = rp_r + 2'h1;
      end
      cnt_nxt = cnt_r + 3'(do_push) - 3'(do_pop);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wp_r <= 2'h0;
         rp_r <= 2'h0;
         cnt_r <= 3'h0;
         for (int i = 0; i < dp_pkg::FDEPTH; i++) mem_r[i] <= dp_pkg::RST_WORD;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         mem_r <= mem_nxt;
      end
   end

   assign p.rdata = mem_r[rp_r];
   assign p.empty = (cnt_r == 3'h0);
   assign p.full = (cnt_r == 3'(dp_pkg::FDEPTH));

   a_push_full: assert property (@(posedge clk) disable iff (srst)
      (p.full && p.push && !p.pop) |=> (cnt_r == 3'(dp_pkg::FDEPTH)) && $stable(wp_r))
      else $error("push on full changed the FIFO");
   a_pop_empty: assert property (@(posedge clk) disable iff (srst)
      (p.empty && p.pop && !p.push) |=> p.empty && $stable(rp_r))
      else $error("pop on empty changed the FIFO");
   a_flag_excl: assert property (@(posedge clk) disable iff (srst)
      !(p.empty && p.full) && (cnt_r <= 3'(dp_pkg::FDEPTH)))
      else $error("FIFO count out of range");
   a_count_track: assert property (@(posedge clk) disable iff (srst)
      (p.push && !p.pop && !p.full) |=> cnt_r == $past(cnt_r) + 3'h1)
      else $error("FIFO count missed a push");
endmodule // byte_fifo

// file: hw/datapath_slice.sv
// Purpose: 8-bit programmable datapath slice with status and control registers.
// Assumes: Register port strobes are one cycle; routing inputs valid every cycle.
// Notes: Chain and routing outputs are registered, so neighbours see them one cycle late.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
module datapath_slice (
   input wire logic clk, // Clock, 25 MHz
   input wire logic srst, // Sync reset, active high
   input wire logic [4:0] addr, // Register address
   input wire logic [7:0] wdata, // Register write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after rd
   input wire logic [5:0] route_in, // Op[2:0], set, serial in, FIFO strobe
   output logic [5:0] route_out, // Selected conditions to routing
   output logic [7:0] ctl_out, // Control register bits to routing
   input wire logic [7:0] stat_in, // Routing signals for status
   input wire logic chain_ci, // Carry from neighbour
   input wire logic chain_si, // Shift data from neighbour
   input wire logic chain_zi, // Zero condition from neighbour
   input wire logic chain_ei, // Equal condition from neighbour
   output logic chain_co, // Carry to neighbour
   output logic chain_so, // Shift data to neighbour
   output logic chain_zo, // Chained zero to neighbour
   output logic chain_eo // Chained equal to neighbour
);
   logic [7:0] acc_r [2];
   logic [7:0] acc_nxt [2];
   logic [7:0] dat_r [2];
   logic [7:0] dat_nxt [2];
   logic [7:0] cfg_r, cfg_nxt, cfg2_r, cfg2_nxt, poly_r, poly_nxt, cmask_r, cmask_nxt;
   logic [7:0] ormask_r, ormask_nxt, ctrl_r, ctrl_nxt, stat_r, stat_nxt;
   logic [7:0] smode_r, smode_nxt, stsel_r, stsel_nxt, rdata_r, rdata_nxt;
   logic [3:0] osel_r [dp_pkg::NROUTE];
   logic [3:0] osel_nxt [dp_pkg::NROUTE];
   logic [5:0] rout_r, rout_nxt;
   logic cy_r, cy_nxt, so_r, so_nxt, ov_r, ov_nxt, zo_r, zo_nxt, eo_r, eo_nxt;
   logic set, chain, sin, cin, run, fb, ov, co, so;
   logic [2:0] msb;
   logic [7:0] wm, a, d, r, m, b1;
   logic [8:0] sum;
   logic [15:0] cond;
   dp_pkg::op_t op;
   dp_pkg::sh_t sh;
   logic f_push [2];
   logic f_pop [2];
   logic [7:0] f_wd [2];
   logic [7:0] f_rd [2];
   logic f_empty [2];
   logic f_full [2];

   fifo_if fq[2] ();
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_fifo
         byte_fifo u_fifo (.clk(clk), .srst(srst), .p(fq[g].store));
         assign fq[g].push = f_push[g];
         assign fq[g].pop = f_pop[g];
         assign fq[g].wdata = f_wd[g];
         assign f_rd[g] = fq[g].rdata;
         assign f_empty[g] = fq[g].empty;
         assign f_full[g] = fq[g].full;
      end
   endgenerate

   always_comb begin
      set = route_in[dp_pkg::R_SET];
      op = dp_pkg::op_t'(route_in[2:0]);
      sh = dp_pkg::sh_t'(cfg2_r[1:0]);
      msb = cfg_r[2:0];
      wm = 8'((9'h002 << msb) - 9'h001);
      a = acc_r[set];
      d = dat_r[set];
      chain = cfg_r[dp_pkg::C_CHAIN];
      sin = chain ? chain_si : route_in[dp_pkg::R_SIN];
      // Set 1 picks up the carry that set 0 left behind, forming a 16-bit word
      cin = (cfg_r[dp_pkg::C_TMUX] && set) ? cy_r : (chain && chain_ci);
      run = !cfg2_r[dp_pkg::X_RGATE] || ctrl_r[cfg2_r[5:3]];
      fb = a[msb] ^ (cfg_r[dp_pkg::C_PRS] ? 1'b0 : sin);
      ov = 1'b0;
      unique case (op)
         dp_pkg::OP_PASS: sum = {1'b0, a};
         dp_pkg::OP_INC: sum = {1'b0, a} + 9'h001;
         dp_pkg::OP_DEC: sum = {1'b0, a} - 9'h001;
         dp_pkg::OP_ADD: begin
            sum = {1'b0, a} + {1'b0, d} + {8'h00, cin};
            ov = (a[msb] == d[msb]) && (sum[msb] != a[msb]);
         end
         dp_pkg::OP_SUB: begin
            sum = {1'b0, a} - {1'b0, d};
            ov = (a[msb] != d[msb]) && (sum[msb] != a[msb]);
         end
         dp_pkg::OP_XOR: sum = {1'b0, a ^ d};
         dp_pkg::OP_AND: sum = {1'b0, a & d};
         dp_pkg::OP_CRC: sum = {1'b0, ((a << 1) & wm) ^ (fb ? poly_r : 8'h00)};
      endcase
      co = (op == dp_pkg::OP_CRC) ? a[msb] : sum[4'(msb) + 4'h1];
      so = a[msb];
      r = sum[7:0] & wm;
      unique case (sh)
         dp_pkg::SH_NONE: r = r;
         dp_pkg::SH_LEFT: begin
            so = r[msb];
            r = {r[6:0], sin};
         end
         dp_pkg::SH_RIGHT: begin
            so = r[0];
            r = r >> 1;
            r[msb] = sin;
         end
         dp_pkg::SH_SWAP: r = {r[3:0], r[7:4]};
      endcase
      r = (r | ormask_r) & wm;

      // Conditions
      m = cmask_r & wm;
      b1 = cfg2_r[dp_pkg::X_CSEL] ? acc_r[0] : dat_r[1];
      cond[0] = ((acc_r[0] & wm) == 8'h00) && (!chain || chain_zi);
      cond[1] = (acc_r[1] & wm) == 8'h00;
      cond[2] = (acc_r[0] & wm) == wm;
      cond[3] = (acc_r[1] & wm) == wm;
      cond[4] = ((acc_r[0] & m) == (dat_r[0] & m)) && (!chain || chain_ei);
      cond[5] = (acc_r[0] & m) < (dat_r[0] & m);
      cond[6] = (acc_r[1] & m) == (b1 & m);
      cond[7] = (acc_r[1] & m) < (b1 & m);
      cond[8] = ov_r;
      cond[9] = cy_r;
      cond[10] = so_r;
      cond[11] = f_empty[0];
      cond[12] = f_full[0];
      cond[13] = f_empty[1];
      cond[14] = f_full[1];
      cond[15] = cond[0] && cond[1];

      acc_nxt = acc_r;
      dat_nxt = dat_r;
      cy_nxt = cy_r;
      so_nxt = so_r;
      ov_nxt = ov_r;
      for (int i = 0; i < 2; i++) begin
         f_push[i] = 1'b0;
         f_pop[i] = 1'b0;
         f_wd[i] = wdata;
      end
      if (run) begin
         acc_nxt[set] = r;
         cy_nxt = co;
         so_nxt = so;
         ov_nxt = ov;
         if (route_in[dp_pkg::R_FSTB]) begin
            if (cfg_r[dp_pkg::C_F0OUT + 32'(set)]) begin
               f_push[set] = 1'b1;
               f_wd[set] = r;
            end else if (!f_empty[set]) begin
               f_pop[set] = 1'b1;
               dat_nxt[set] = f_rd[set];
            end
         end
      end
      zo_nxt = cond[0];
      eo_nxt = cond[4];

      cfg_nxt = cfg_r;
      cfg2_nxt = cfg2_r;
      poly_nxt = poly_r;
      cmask_nxt = cmask_r;
      ormask_nxt = ormask_r;
      ctrl_nxt = ctrl_r;
      smode_nxt = smode_r;
      stsel_nxt = stsel_r;
      osel_nxt = osel_r;
      // Software writes to the operand registers win over the datapath
      if (wr) begin
         unique case (addr)
            dp_pkg::A_ACC0: acc_nxt[0] = wdata;
            dp_pkg::A_ACC1: acc_nxt[1] = wdata;
            dp_pkg::A_DAT0: dat_nxt[0] = wdata;
            dp_pkg::A_DAT1: dat_nxt[1] = wdata;
            // An ignored bus write must not cancel a datapath push in the same cycle
            dp_pkg::A_FIFO0: f_push[0] = f_push[0] || !cfg_r[dp_pkg::C_F0OUT];
            dp_pkg::A_FIFO1: f_push[1] = f_push[1] || !cfg_r[dp_pkg::C_F0OUT + 1];
            dp_pkg::A_CFG: cfg_nxt = wdata;
            dp_pkg::A_POLY: poly_nxt = wdata;
            dp_pkg::A_CMASK: cmask_nxt = wdata;
            dp_pkg::A_ORMASK: ormask_nxt = wdata;
            5'h0a, 5'h0b, 5'h0c: begin
               osel_nxt[2 * (addr - dp_pkg::A_OSEL)] = wdata[3:0];
               osel_nxt[2 * (addr - dp_pkg::A_OSEL) + 1] = wdata[7:4];
            end
            dp_pkg::A_CTRL: ctrl_nxt = wdata;
            dp_pkg::A_SMODE: smode_nxt = wdata;
            dp_pkg::A_STSEL: stsel_nxt = wdata;
            dp_pkg::A_CFG2: cfg2_nxt = wdata;
            default: ;
         endcase
      end

      rdata_nxt = 8'h00;
      if (rd) begin
         unique case (addr)
            dp_pkg::A_ACC0: rdata_nxt = acc_r[0];
            dp_pkg::A_ACC1: rdata_nxt = acc_r[1];
            dp_pkg::A_DAT0: rdata_nxt = dat_r[0];
            dp_pkg::A_DAT1: rdata_nxt = dat_r[1];
            dp_pkg::A_FIFO0, dp_pkg::A_FIFO1: begin
               if (cfg_r[dp_pkg::C_F0OUT + 32'(addr[0])] && !f_empty[addr[0]]) begin
                  f_pop[addr[0]] = 1'b1;
                  rdata_nxt = f_rd[addr[0]];
               end
            end
            dp_pkg::A_CFG: rdata_nxt = cfg_r;
            dp_pkg::A_POLY: rdata_nxt = poly_r;
            dp_pkg::A_CMASK: rdata_nxt = cmask_r;
            dp_pkg::A_ORMASK: rdata_nxt = ormask_r;
            5'h0a, 5'h0b, 5'h0c: rdata_nxt = {osel_r[2 * (addr - dp_pkg::A_OSEL) + 1],
                                             osel_r[2 * (addr - dp_pkg::A_OSEL)]};
            dp_pkg::A_CTRL: rdata_nxt = ctrl_r;
            dp_pkg::A_STAT: rdata_nxt = stat_r;
            dp_pkg::A_SMODE: rdata_nxt = smode_r;
            dp_pkg::A_STSEL: rdata_nxt = stsel_r;
            dp_pkg::A_CFG2: rdata_nxt = cfg2_r;
            default: rdata_nxt = 8'h00;
         endcase
      end

      // A new event in the reading cycle survives the clear
      for (int i = 0; i < 8; i++) begin
         logic src;
         src = stsel_r[i] ? cond[i] : stat_in[i];
         stat_nxt[i] = smode_r[i] ? (src || (stat_r[i] && !(rd && addr == dp_pkg::A_STAT))) : src;
      end
      for (int i = 0; i < dp_pkg::NROUTE; i++) begin
         rout_nxt[i] = cond[osel_r[i]];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 2; i++) begin
            acc_r[i] <= dp_pkg::RST_WORD;
            dat_r[i] <= dp_pkg::RST_WORD;
         end
         for (int i = 0; i < dp_pkg::NROUTE; i++) osel_r[i] <= dp_pkg::RST_OSEL;
         cfg_r <= dp_pkg::RST_CFG;
         cfg2_r <= dp_pkg::RST_WORD;
         poly_r <= dp_pkg::RST_WORD;
         cmask_r <= dp_pkg::RST_CMASK;
         ormask_r <= dp_pkg::RST_WORD;
         ctrl_r <= dp_pkg::RST_WORD;
         stat_r <= dp_pkg::RST_WORD;
         smode_r <= dp_pkg::RST_WORD;
         stsel_r <= dp_pkg::RST_WORD;
         rdata_r <= dp_pkg::RST_WORD;
         rout_r <= 6'h00;
         {cy_r, so_r, ov_r, zo_r, eo_r} <= 5'h00;
      end else begin
         acc_r <= acc_nxt;
         dat_r <= dat_nxt;
         osel_r <= osel_nxt;
         cfg_r <= cfg_nxt;
         cfg2_r <= cfg2_nxt;
         poly_r <= poly_nxt;
         cmask_r <= cmask_nxt;
         ormask_r <= ormask_nxt;
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         smode_r <= smode_nxt;
         stsel_r <= stsel_nxt;
         rdata_r <= rdata_nxt;
         rout_r <= rout_nxt;
         {cy_r, so_r, ov_r, zo_r, eo_r} <= {cy_nxt, so_nxt, ov_nxt, zo_nxt, eo_nxt};
      end
   end

   assign rdata = rdata_r;
   assign route_out = rout_r;
   assign ctl_out = ctrl_r;
   assign chain_co = cy_r;
   assign chain_so = so_r;
   assign chain_zo = zo_r;
   assign chain_eo = eo_r;

   a_stat_clear: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == dp_pkg::A_STAT)
      |=> (stat_r & $past(~stsel_r & ~stat_in)) == 8'h00)
      else $error("status read did not clear held bits");
   a_route_sel: assert property (@(posedge clk) disable iff (srst)
      !srst |=> route_out[0] == $past(cond[osel_r[0]]))
      else $error("routing output 0 not the selected condition");
   a_ctrl_read: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == dp_pkg::A_CTRL) |=> rdata == $past(ctl_out))
      else $error("control read mismatch");
   a_inc_step: assert property (@(posedge clk) disable iff (srst)
      (run && !set && op == dp_pkg::OP_INC && sh == dp_pkg::SH_NONE && ormask_r == 8'h00
       && !(wr && addr == dp_pkg::A_ACC0))
      |=> acc_r[0] == (($past(acc_r[0]) + 8'h01) & $past(wm)))
      else $error("increment ignored the programmed width");
endmodule // datapath_slice

// file: tb/routing_partner.sv
// Purpose: Routing matrix and neighbour slice model driving the slice inputs.
// Assumes: Bench changes the request fields just after a rising edge.
// Notes: Neighbour lines are steady levels, as a live chain is.
`timescale 1ns/1ns
module routing_partner (
   input wire logic [2:0] op, // Operation request
   input wire logic set, // Register set
   input wire logic sin, // Serial data
   input wire logic stb, // FIFO strobe
   input wire logic [3:0] nb, // Neighbour carry, shift, zero, equal
   output logic [5:0] route_in, // Routing inputs to the slice
   output logic [3:0] chain // Neighbour levels to the slice
);
   // Idle is pass rather than a floating field, so every cycle names an operation
   assign route_in = {stb, sin, set, op};
   assign chain = nb;
endmodule // routing_partner

// file: tb/programmable_datapath_slice_tb.sv
// Purpose: Self-checking bench for the datapath slice over its register port.
// Assumes: Latencies as handed over: read data one cycle, routing outputs one more.
// Notes: Idle cycles run pass, so shift modes use set 1 as the idle set.
`timescale 1ns/1ns
module programmable_datapath_slice_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] stat_in = 8'h00;
   logic [2:0] op = 3'h0;
   logic set = 1'b0;
   logic sin = 1'b0;
   logic stb = 1'b0;
   logic idle_set = 1'b0;
   logic [3:0] nb = 4'h3;
   logic [7:0] rdata;
   logic [7:0] ctl_out;
   logic [5:0] route_in;
   logic [5:0] route_out;
   logic [3:0] chain_n;
   logic [3:0] chain_o;
   logic [7:0] sh_cfg [3] = '{8'h01, 8'h03, 8'h02};
   logic [7:0] sh_exp [3] = '{8'h03, 8'h30, 8'h98};
   int fails = 0;
   int cmp_count = 0;

   always #20 clk = ~clk;

   routing_partner u_routing_partner (.op(op), .set(set), .sin(sin), .stb(stb), .nb(nb),
      .route_in(route_in), .chain(chain_n));

   datapath_slice u_datapath_slice (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .route_in(route_in), .route_out(route_out), .ctl_out(ctl_out),
      .stat_in(stat_in), .chain_ci(chain_n[3]), .chain_si(chain_n[2]), .chain_zi(chain_n[1]),
      .chain_ei(chain_n[0]), .chain_co(chain_o[3]), .chain_so(chain_o[2]), .chain_zo(chain_o[1]),
      .chain_eo(chain_o[0]));

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp, what);
   endtask

   // One operation for one cycle, then back to idle pass
   task automatic step(input logic [2:0] o, input logic s, input logic si, input logic fs);
      @(posedge clk);
      op <= o;
      set <= s;
      sin <= si;
      stb <= fs;
      @(posedge clk);
      op <= 3'h0;
      set <= idle_set;
      stb <= 1'b0;
      @(negedge clk);
   endtask

   // Select conditions for outputs 0 and 1, then look at them
   task automatic rout(input logic [7:0] sel, input logic [1:0] exp, input string what);
      wreg(dp_pkg::A_OSEL, sel);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({6'h00, route_out[1:0]}, {6'h00, exp}, what);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rchk(dp_pkg::A_CFG, 8'h07, "cfg reset");
      rchk(dp_pkg::A_CMASK, 8'hff, "cmask reset");
      rchk(5'h1f, 8'h00, "unmapped");
      chk({2'b00, route_out}, 8'h3f, "zero on all outputs");
      chk({6'h00, chain_o[1:0]}, 8'h03, "zero and equal out");
      wreg(dp_pkg::A_CTRL, 8'ha5);
      @(negedge clk);
      chk(ctl_out, 8'ha5, "ctl out");
      rchk(dp_pkg::A_CTRL, 8'ha5, "ctl read");
      wreg(dp_pkg::A_CFG2, 8'h48);
      step(dp_pkg::OP_INC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h00, "gated off");
      wreg(dp_pkg::A_CTRL, 8'h02);
      step(dp_pkg::OP_INC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h01, "gated on");
      wreg(dp_pkg::A_CFG2, 8'h00);
      wreg(dp_pkg::A_ACC0, 8'h12);
      wreg(dp_pkg::A_DAT0, 8'h12);
      rout(8'h54, 2'b01, "equal");
      wreg(dp_pkg::A_DAT0, 8'h13);
      rout(8'h54, 2'b10, "less");
      wreg(dp_pkg::A_CMASK, 8'hfe);
      rout(8'h54, 2'b01, "masked equal");
      wreg(dp_pkg::A_CMASK, 8'hff);
      wreg(dp_pkg::A_DAT0, 8'h12);
      wreg(dp_pkg::A_CFG, 8'h47);
      nb <= 4'h2;
      rout(8'h54, 2'b00, "chained unequal");
      nb <= 4'h3;
      rout(8'h54, 2'b01, "chained equal");
      chk({7'h00, chain_o[0]}, 8'h01, "equal to neighbour");
      wreg(dp_pkg::A_CFG, 8'h03);
      wreg(dp_pkg::A_ACC0, 8'h0f);
      step(dp_pkg::OP_INC, 1'b0, 1'b0, 1'b0);
      chk({7'h00, chain_o[3]}, 8'h01, "carry at msb");
      chk({7'h00, chain_o[2]}, 8'h01, "shift out at msb");
      rchk(dp_pkg::A_ACC0, 8'h00, "narrow wrap");
      wreg(dp_pkg::A_CFG, 8'h87);
      wreg(dp_pkg::A_POLY, 8'h1d);
      wreg(dp_pkg::A_ACC0, 8'h80);
      step(dp_pkg::OP_CRC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h1d, "crc feedback");
      step(dp_pkg::OP_CRC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h3a, "crc plain shift");
      wreg(dp_pkg::A_CFG, 8'h83);
      wreg(dp_pkg::A_POLY, 8'h03);
      wreg(dp_pkg::A_ACC0, 8'h08);
      step(dp_pkg::OP_CRC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h03, "crc width 4");
      wreg(dp_pkg::A_CFG, 8'h47);
      wreg(dp_pkg::A_POLY, 8'h1d);
      wreg(dp_pkg::A_ACC0, 8'h00);
      nb <= 4'h7;
      step(dp_pkg::OP_CRC, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      nb <= 4'h3;
      rchk(dp_pkg::A_ACC0, 8'h1d, "crc chained in");
      wreg(dp_pkg::A_CFG, 8'h27);
      wreg(dp_pkg::A_ACC0, 8'hff);
      wreg(dp_pkg::A_DAT0, 8'h01);
      wreg(dp_pkg::A_ACC1, 8'h00);
      wreg(dp_pkg::A_DAT1, 8'h00);
      // Low then high half back to back, or an idle pass clears the carry
      @(posedge clk);
      op <= dp_pkg::OP_ADD;
      @(posedge clk);
      set <= 1'b1;
      @(posedge clk);
      op <= dp_pkg::OP_PASS;
      set <= 1'b0;
      rchk(dp_pkg::A_ACC0, 8'h00, "low half");
      rchk(dp_pkg::A_ACC1, 8'h01, "high half carry");
      wreg(dp_pkg::A_CFG, 8'h07);
      wreg(dp_pkg::A_ACC0, 8'h81);
      @(posedge clk);
      idle_set = 1'b1;
      set <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wreg(dp_pkg::A_CFG2, sh_cfg[i]);
         step(dp_pkg::OP_PASS, 1'b0, 1'b1, 1'b0);
         rchk(dp_pkg::A_ACC0, sh_exp[i], "shift mode");
      end
      wreg(dp_pkg::A_CFG2, 8'h00);
      wreg(dp_pkg::A_ORMASK, 8'h40);
      step(dp_pkg::OP_PASS, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'hd8, "or mask");
      wreg(dp_pkg::A_ORMASK, 8'h00);
      idle_set = 1'b0;
      wreg(dp_pkg::A_CFG, 8'h0f);
      wreg(dp_pkg::A_ACC0, 8'h10);
      // Five pushes into four places: the last one must be dropped
      @(posedge clk);
      op <= dp_pkg::OP_INC;
      set <= 1'b0;
      stb <= 1'b1;
      repeat (5) @(posedge clk);
      op <= dp_pkg::OP_PASS;
      stb <= 1'b0;
      rout(8'hbc, 2'b01, "fifo0 full");
      wreg(dp_pkg::A_FIFO0, 8'h77);
      for (int i = 0; i < 4; i++) begin
         rchk(dp_pkg::A_FIFO0, 8'h11 + 8'(i), "fifo0 order");
      end
      rchk(dp_pkg::A_FIFO0, 8'h00, "fifo0 underflow");
      rout(8'hbc, 2'b10, "fifo0 empty");
      rchk(dp_pkg::A_ACC0, 8'h15, "acc after pushes");
      wreg(dp_pkg::A_FIFO1, 8'h5a);
      wreg(dp_pkg::A_FIFO1, 8'h6b);
      step(dp_pkg::OP_PASS, 1'b1, 1'b0, 1'b1);
      rchk(dp_pkg::A_DAT1, 8'h5a, "fifo1 first");
      step(dp_pkg::OP_PASS, 1'b1, 1'b0, 1'b1);
      step(dp_pkg::OP_PASS, 1'b1, 1'b0, 1'b1);
      rchk(dp_pkg::A_DAT1, 8'h6b, "fifo1 empty pop");
      wreg(dp_pkg::A_SMODE, 8'h01);
      @(posedge clk);
      stat_in <= 8'h03;
      @(posedge clk);
      stat_in <= 8'h02;
      rchk(dp_pkg::A_STAT, 8'h03, "sticky held");
      rchk(dp_pkg::A_STAT, 8'h02, "sticky cleared");
      wreg(dp_pkg::A_STAT, 8'hff);
      @(posedge clk);
      stat_in <= 8'h00;
      rchk(dp_pkg::A_STAT, 8'h00, "status read only");
      wreg(dp_pkg::A_ACC0, 8'hff);
      wreg(dp_pkg::A_STSEL, 8'h04);
      rchk(dp_pkg::A_STAT, 8'h04, "status from condition");
      rout(8'h20, 2'b10, "all ones");
      // Overflow is a one-cycle pulse, so the selection is set up before the add
      wreg(dp_pkg::A_OSEL, 8'h98);
      wreg(dp_pkg::A_ACC0, 8'h7f);
      wreg(dp_pkg::A_DAT0, 8'h01);
      step(dp_pkg::OP_ADD, 1'b0, 1'b0, 1'b0);
      @(negedge clk);
      chk({6'h00, route_out[1:0]}, 8'h01, "overflow pulse");
      step(dp_pkg::OP_SUB, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h7f, "sub");
      step(dp_pkg::OP_XOR, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h7e, "xor");
      step(dp_pkg::OP_DEC, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h7d, "dec");
      step(dp_pkg::OP_AND, 1'b0, 1'b0, 1'b0);
      rchk(dp_pkg::A_ACC0, 8'h01, "and");
      summarize();
   end
endmodule // programmable_datapath_slice_tb
